// ---- tb/ocs_ext_osc.sv ----
// external oscillator model: cmos clock or crystal on the oscillator pin
`timescale 1ns/1ns
`default_nettype none
module ocs_ext_osc #(
   parameter int HALF_NS = 37 // 13.5 MHz, below the fastest core clock
) (
   // control
   input  wire logic run,
   // pin
   output var logic  pin
);
   // starts low, stands still while stopped
   initial pin = 1'b0;
   // free running half periods, unrelated to the base clock
   always #(HALF_NS) if (run) pin = ~pin;
endmodule // ocs_ext_osc
`default_nettype wire

// ---- tb/ocs_top_chk.sv ----
// concurrent checks on the ports of the clock select block
`timescale 1ns/1ns
`default_nettype none
`include "ocs_consts.svh"
module ocs_top_chk #(
   parameter logic [6:0]  TRIM_RESET        = `OCS_TRIM_RESET,
   parameter int unsigned XTAL_STABLE_EDGES = `OCS_XTAL_STABLE_EDGES
) (
   // clock and reset
   input wire logic                     clk,
   input wire logic                     reset_n,
   // register port
   input wire ocs_pkg::ocs_sfr_req_type sfr_req,
   input wire logic [7:0]               sfr_rdata,
   // pins
   input wire logic                     crystal_pin_out_level,
   input wire logic                     p02_osc_claim,
   input wire logic                     p03_osc_claim,
   // analog settings and enables
   input wire logic                     internal_osc_on,
   input wire logic [6:0]               internal_osc_trim,
   input wire logic [2:0]               external_freq_range,
   input wire logic                     core_clock,
   input wire logic                     ext_div8_tick
);
   import ocs_pkg::*;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);
   a_trim_read: assert property (sfr_req.rd && sfr_req.addr == 8'hb3 |=>
      sfr_rdata == {1'b0, internal_osc_trim}) else $error("trim readback wrong");
   a_ctrl_unused: assert property (sfr_req.rd && sfr_req.addr == 8'hb2 |=>
      sfr_rdata[5:2] == 4'h0 && sfr_rdata[7] == internal_osc_on) else $error("control readback wrong");
   a_ready_needs_on: assert property (sfr_req.rd && sfr_req.addr == 8'hb2 |=>
      !sfr_rdata[6] || sfr_rdata[7]) else $error("ready while oscillator off");
   a_osc_enable: assert property (sfr_req.wr && sfr_req.addr == 8'hb2 |=>
      internal_osc_on == $past(sfr_req.wdata[7])) else $error("enable not taken");
   a_trim_write: assert property (sfr_req.wr && sfr_req.addr == 8'hb3 |=>
      internal_osc_trim == $past(sfr_req.wdata[6:0])) else $error("trim not taken");
   a_trim_reset: assert property ($rose(reset_n) |->
      internal_osc_trim == TRIM_RESET && internal_osc_on) else $error("reset settings wrong");
   a_ext_decode: assert property (sfr_req.wr && sfr_req.addr == 8'hb1 |=>
      p02_osc_claim == ($past(sfr_req.wdata[6:5]) == 2'b11) &&
      p03_osc_claim == ($past(sfr_req.wdata[6:5]) != 2'b00) &&
      external_freq_range == $past(sfr_req.wdata[2:0])) else $error("mode decode wrong");
   a_xtal_pins: assert property (p02_osc_claim |-> p03_osc_claim)
      else $error("crystal pin claimed alone");
   a_src_read: assert property (sfr_req.rd && sfr_req.addr == 8'ha9 |=>
      sfr_rdata[7:2] == 6'h00) else $error("source readback wrong");
   a_mult_read: assert property (sfr_req.rd && sfr_req.addr == 8'hbe |=>
      sfr_rdata[4:2] == 3'h0 && sfr_rdata[1:0] != 2'b11) else $error("multiplier readback wrong");
   a_tick_single: assert property (ext_div8_tick |=> !ext_div8_tick)
      else $error("peripheral tick too long");
   a_xtal_valid: assert property (sfr_req.rd && sfr_req.addr == 8'hb1 && !p02_osc_claim |=>
      !sfr_rdata[7]) else $error("valid outside crystal mode");
endmodule // ocs_top_chk
`default_nettype wire

// ---- tb/tb_top.sv ----
// self-checking bench for the clock select block
`timescale 1ns/1ns
`default_nettype none
`include "ocs_consts.svh"
module tb_top;
   import ocs_pkg::*;
   logic            clk = 1'b0;
   logic            reset_n = 1'b0;
   ocs_sfr_req_type req = '0;
   logic [7:0]      rdata, r;
   logic            pin, p02, p03, osc_on, cclk, xtick;
   logic            run = 1'b0;
   logic [6:0]      trim;
   logic [2:0]      rng;
   int              fail_count = 0;
   int              n_checks = 0;
   int              cyc = 0;
   int              pins = 0;
   int              cc, xc, ep, e, k;
   // rows: address, write data, read mask, expected read
   localparam logic [31:0] ROWS [10] = '{32'hb3ff_ff7f, 32'hb340_ff40, 32'hb2ff_bf83, 32'hb15f_7f57,
      32'hb100_ff00, 32'hbe83_df80, 32'hbe02_df02, 32'hbe00_df00, 32'ha9ff_ff00, 32'h55ff_ff00};
   // base clock, 8 ns
   always #4 clk = ~clk;
   // oscillator pin edges seen by the bench
   always @(posedge pin) pins++;
   ocs_ext_osc ocs_ext_osc_inst (.run(run), .pin(pin));
   ocs_top #(.XTAL_STABLE_EDGES(8)) ocs_top_inst (.clk(clk), .reset_n(reset_n), .sfr_req(req),
      .sfr_rdata(rdata), .crystal_pin_out_level(pin), .p02_osc_claim(p02), .p03_osc_claim(p03),
      .internal_osc_on(osc_on), .internal_osc_trim(trim), .external_freq_range(rng),
      .core_clock(cclk), .ext_div8_tick(xtick));
   // register write, one cycle strobe
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk);
      req = '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(negedge clk);
      req = '0;
   endtask
   // register read, data one cycle later
   task automatic rd(input logic [7:0] a, output logic [7:0] q);
      @(negedge clk);
      req = '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(negedge clk);
      req = '0;
      q = rdata;
   endtask
   task automatic chk(input logic [7:0] s, input logic [7:0] x);
      n_checks++;
      if (s !== x)
      begin
         fail_count++;
         $display("mismatch at %0t: seen %h expected %h", $time, s, x);
      end
   endtask
   task automatic chk_rng(input int s, input int lo, input int hi);
      chk(8'((s >= lo && s <= hi) ? 1 : 0), 8'h01);
   endtask
   // counts core and peripheral pulses and pin edges over a window
   task automatic count(input int len);
      int p0;
      p0 = pins;
      cc = 0;
      xc = 0;
      repeat (len)
      begin
         @(posedge clk);
         #1;
         if (cclk === 1'b1) cc++;
         if (xtick === 1'b1) xc++;
      end
      ep = pins - p0;
   endtask
   task automatic close_out;
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   // run limit
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 60000)
      begin
         fail_count++;
         close_out();
      end
   end
   initial
   begin
      // internal ticks in 4096 cycles at trim 64
      e = (4096 * (`OCS_NCO_BASE + 64 * `OCS_NCO_STEP)) / 65536;
      repeat (12) @(negedge clk);
      reset_n = 1'b1;
      repeat (150) @(negedge clk);
      rd(8'hb2, r); chk(r, 8'hc0);
      rd(8'hb3, r); chk(r, 8'h40);
      rd(8'ha9, r); chk(r, 8'h00);
      count(4096); chk_rng(cc, e / 8 - 2, e / 8 + 2);
      foreach (ROWS[i])
      begin
         wr(ROWS[i][31:24], ROWS[i][23:16]);
         rd(ROWS[i][31:24], r);
         chk(r & ROWS[i][15:8], ROWS[i][7:0]);
      end
      for (k = 0; k < 4; k++)
      begin
         wr(8'hb2, 8'h80 | 8'(k));
         repeat (100) @(negedge clk);
         count(4096); chk_rng(cc, (e >> (3 - k)) - 2, (e >> (3 - k)) + 2);
      end
      // cmos clock on the pin, core at divide by one
      run = 1'b1;
      wr(8'hb1, 8'h20);
      chk({6'h0, p02, p03}, 8'h01);
      count(800); chk_rng(xc, ep / 8 - 1, ep / 8 + 1);
      wr(8'ha9, 8'h01);
      repeat (50) @(negedge clk);
      count(800); chk_rng(cc, ep - 2, ep + 2);
      wr(8'ha9, 8'h00);
      // cmos clock with the divide by two stage
      wr(8'hb1, 8'h30);
      count(1600); chk_rng(xc, ep / 16 - 1, ep / 16 + 1);
      // crystal start: enable, read valid clear, wait 200 cycles, read valid set
      wr(8'hb1, 8'h67);
      rd(8'hb1, r); chk({r[7], p02, p03, 2'h0, rng}, 8'h67);
      repeat (200) @(negedge clk);
      rd(8'hb1, r); chk(r, 8'he7);
      wr(8'hb1, 8'h00);
      rd(8'hb1, r); chk({r[7], p02, p03}, 8'h00);
      run = 1'b0;
      // multiplier on internal over two
      wr(8'hbe, 8'h80);
      repeat (20) @(negedge clk);
      wr(8'hbe, 8'hc0);
      r = 8'h00;
      for (k = 0; k < 50 && r[5] !== 1'b1; k++) rd(8'hbe, r);
      chk(r & 8'hbf, 8'ha0);
      wr(8'ha9, 8'h02);
      repeat (100) @(negedge clk);
      count(4096); chk_rng(cc, 2 * e - 8, 2 * e + 8);
      wr(8'ha9, 8'h00);
      // oscillator off stops the internal source
      wr(8'hb2, 8'h03);
      rd(8'hb2, r); chk({r[7:6], 5'h0, osc_on}, 8'h00);
      repeat (50) @(negedge clk);
      count(1000); chk_rng(cc, 0, 0);
      wr(8'hb2, 8'h83);
      r = 8'h00;
      for (k = 0; k < 100 && r[6] !== 1'b1; k++) rd(8'hb2, r);
      chk(r, 8'hc3);
      // second reset in mid-run
      @(negedge clk);
      reset_n = 1'b0;
      repeat (3) @(negedge clk);
      reset_n = 1'b1;
      rd(8'hb2, r); chk(r & 8'hbf, 8'h80);
      rd(8'ha9, r); chk(r, 8'h00);
      close_out();
   end
endmodule // tb_top
bind ocs_top ocs_top_chk #(.TRIM_RESET(TRIM_RESET), .XTAL_STABLE_EDGES(XTAL_STABLE_EDGES)) ocs_top_chk_inst (
   .clk(clk), .reset_n(reset_n), .sfr_req(sfr_req), .sfr_rdata(sfr_rdata),
   .crystal_pin_out_level(crystal_pin_out_level), .p02_osc_claim(p02_osc_claim),
   .p03_osc_claim(p03_osc_claim), .internal_osc_on(internal_osc_on), .internal_osc_trim(internal_osc_trim),
   .external_freq_range(external_freq_range), .core_clock(core_clock), .ext_div8_tick(ext_div8_tick));
`default_nettype wire

// ---- verilog/ocs_clock_mult.sv ----
// clock multiplier: four evenly spaced ticks per input tick period
`timescale 1ns/1ns
`default_nettype none
`include "ocs_consts.svh"
module ocs_clock_mult #(
   parameter int unsigned W = `OCS_MULT_W
) (
   // clock and reset
   input  wire logic clk,
   input  wire logic reset_n,
   // control
   input  wire logic enable,
   input  wire logic init,
   input  wire logic in_tick,
   // results
   output logic      out_tick,
   output logic      ready
);
   import ocs_pkg::*;

   // refuse widths too narrow to measure a period
   if (W < 4) begin : g_chk
      $error("ocs_clock_mult: W must be at least 4");
   end

   logic [W-1:0] cnt_q;     // cycles since last input tick
   logic [W-1:0] period_q;  // last measured period
   logic [W-1:0] sub_q;     // cycles since last output tick
   logic [1:0]   slot_q;    // inner output ticks issued this period
   logic [1:0]   meas_q;    // completed measurements since init
   logic [W-1:0] quarter;   // spacing of output ticks
   logic         mid_tick;  // one of the three inner ticks

   assign quarter  = period_q >> 2;
   assign mid_tick = ready && !in_tick && slot_q != 2'h3 && quarter != '0 && sub_q == quarter - 1'b1;

   // period measurement between input ticks
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         cnt_q    <= '0;
         period_q <= '0;
         meas_q   <= 2'h0;
      end
      else if (!enable || init)
      begin
         cnt_q  <= '0;
         meas_q <= 2'h0;
      end
      else if (in_tick)
      begin
         period_q <= cnt_q + 1'b1;
         cnt_q    <= '0;
         if (meas_q != 2'h2)
            meas_q <= meas_q + 2'h1;
      end
      else if (cnt_q != '1)
         cnt_q <= cnt_q + 1'b1;
   end

   // lock once a full period has been measured
   assign ready = enable && meas_q == 2'h2;

   // output tick spacing, realigned on every input tick
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         sub_q  <= '0;
         slot_q <= 2'h0;
      end
      else if (in_tick)
      begin
         sub_q  <= '0;
         slot_q <= 2'h0;
      end
      else if (mid_tick)
      begin
         sub_q  <= '0;
         slot_q <= slot_q + 2'h1;
      end
      else if (sub_q != '1)
         sub_q <= sub_q + 1'b1;
   end

   // four ticks per input period: one aligned, three spaced
   assign out_tick = ready && (in_tick || mid_tick);

endmodule // ocs_clock_mult
`default_nettype wire

// ---- verilog/ocs_consts.svh ----
// constants for the oscillator and core clock select block
// Function
// - core clock runs from internal oscillator after reset
// - trim holds seven bits setting oscillator period
// - trim bit seven reads zero, ignores writes
// - divide code 00/01/10/11 gives 8/4/2/1
// - post-divider resets to divide by eight
// - control bit seven enables oscillator, reset on
// - ready bit set only at programmed frequency
// - control bits five to two read zero
// - external oscillator over eight feeds timers
// - peripheral tick synchronised, half-cycle jitter bound; code samples rising clock edges only, jitter up to one base clock cycle
// - crystal modes claim both pins, other on modes one, off modes none
// - core clock picks internal, external or multiplier
// - multiplier offers internal x2, external x2/x4
// - crystal valid read-only, set once stable
// - external mode field decodes eight codes
// - source select 00/01/10, 11 reserved
// - multiplier output four times its input
`ifndef OCS_CONSTS_SVH
`define OCS_CONSTS_SVH

// register addresses
`define OCS_ADDR_EXT_CTRL       8'hb1
`define OCS_ADDR_INT_CTRL       8'hb2
`define OCS_ADDR_INT_TRIM       8'hb3
`define OCS_ADDR_MULT_CTRL      8'hbe
`define OCS_ADDR_CLK_SEL        8'ha9

// internal oscillator control fields
`define OCS_INT_EN_BIT          7
`define OCS_INT_RDY_BIT         6
`define OCS_INT_CTRL_RESET      8'hc0
`define OCS_DIV_RESET           2'h0

// multiplier control fields
`define OCS_MUL_EN_BIT          7
`define OCS_MUL_INIT_BIT        6
`define OCS_MUL_RDY_BIT         5

// trim reset and oscillator model (125 MHz base, 24.5 MHz at reset trim)
`define OCS_TRIM_RESET          7'h40
`define OCS_NCO_W               16
`define OCS_NCO_BASE            16'h222d
`define OCS_NCO_STEP            16'h0040

// settling counts and multiplier counter width
`define OCS_INT_READY_TICKS     4'hf
`define OCS_XTAL_STABLE_EDGES   1024
`define OCS_MULT_W              16

`endif

// ---- verilog/ocs_pkg.sv ----
// types shared by the oscillator and core clock select block
package ocs_pkg;

   // special-function register request from the core
   typedef struct packed {
      logic [7:0] addr;  // register address
      logic [7:0] wdata; // write data
      logic       wr;    // write strobe, one cycle
      logic       rd;    // read strobe, one cycle
   } ocs_sfr_req_type;

   // external oscillator modes
   typedef enum logic [2:0] {
      EXT_OFF0      = 3'h0,
      EXT_OFF1      = 3'h1,
      EXT_CMOS      = 3'h2,
      EXT_CMOS_DIV2 = 3'h3,
      EXT_RC        = 3'h4,
      EXT_CAP       = 3'h5,
      EXT_XTAL      = 3'h6,
      EXT_XTAL_DIV2 = 3'h7
   } ocs_ext_mode_type;

   // core clock sources
   typedef enum logic [1:0] {
      SRC_INT  = 2'h0,
      SRC_EXT  = 2'h1,
      SRC_MULT = 2'h2,
      SRC_RSVD = 2'h3
   } ocs_src_type;

   // source switch states
   typedef enum logic [1:0] {
      SW_RUN  = 2'h0,
      SW_WAIT = 2'h1
   } ocs_sw_state_type;

endpackage

// ---- verilog/ocs_top.sv ----
// oscillator control, core clock selection and peripheral clock tick
`timescale 1ns/1ns
`default_nettype none
`include "ocs_consts.svh"
module ocs_top #(
   parameter logic [6:0]  TRIM_RESET        = `OCS_TRIM_RESET,
   parameter int unsigned XTAL_STABLE_EDGES = `OCS_XTAL_STABLE_EDGES
) (
   // clock and reset
   input  wire logic                    clk,
   input  wire logic                    reset_n,
   // special-function register port
   input  wire ocs_pkg::ocs_sfr_req_type sfr_req,
   output logic [7:0]                   sfr_rdata,
   // oscillator pin sense and pin ownership
   input  wire logic                    crystal_pin_out_level,
   output logic                         p02_osc_claim,
   output logic                         p03_osc_claim,
   // analog settings
   output logic                         internal_osc_on,
   output logic [6:0]                   internal_osc_trim,
   output logic [2:0]                   external_freq_range,
   // clock enables
   output logic                         core_clock,
   output logic                         ext_div8_tick
);
   import ocs_pkg::*;

   // refuse a zero settle count, or one the 16-bit edge counter cannot reach
   if (XTAL_STABLE_EDGES < 1 || XTAL_STABLE_EDGES > 65535) begin : g_chk
      $error("ocs_top: XTAL_STABLE_EDGES must be 1 to 65535");
   end

   // control register reset image, so single bits can be picked from it
   localparam logic [7:0] CTRL_RESET = `OCS_INT_CTRL_RESET;

   // divide code to tick mask of the post-divider
   function automatic logic [2:0] div_mask(input logic [1:0] code);
      case (code)
         2'h0:    div_mask = 3'h7;  // divide by 8
         2'h1:    div_mask = 3'h3;  // divide by 4
         2'h2:    div_mask = 3'h1;  // divide by 2
         default: div_mask = 3'h0;  // divide by 1
      endcase
   endfunction

   // trim code to oscillator phase increment
   function automatic logic [`OCS_NCO_W-1:0] nco_inc(input logic [6:0] trim);
      nco_inc = `OCS_NCO_BASE + ({9'h000, trim} * `OCS_NCO_STEP);
   endfunction

   // register state
   logic             osc_on_q;     // internal oscillator enable
   logic [1:0]       div_q;        // requested divide code
   logic [1:0]       div_act_q;    // divide code in use
   logic [6:0]       trim_q;       // oscillator trim
   ocs_ext_mode_type ext_mode_q;   // external mode
   logic [2:0]       range_q;      // external frequency range
   logic             mul_en_q;     // multiplier enable
   logic [1:0]       mul_sel_q;    // multiplier input
   logic             mul_init_q;   // one-cycle init pulse
   logic             mul_init_bit_q; // stored init bit
   ocs_src_type      src_q;        // requested core source
   ocs_src_type      src_act_q;    // core source in use
   ocs_sw_state_type sw_q;         // switch state
   logic [7:0]       rdata_q;      // read data

   // internal oscillator model
   logic [`OCS_NCO_W-1:0] nco_q;   // phase accumulator
   logic                  nco_cy;  // phase wrap
   logic [`OCS_NCO_W-1:0] nco_sum; // next phase
   logic                  int_tick;
   logic [3:0]            rdy_cnt_q;
   logic                  int_ready;
   logic [2:0]            pd_cnt_q;
   logic                  int_div_tick;
   logic                  int_half_q;

   // external oscillator path
   logic                  ext_s1_q, ext_s2_q, ext_s3_q;
   logic                  ext_on, ext_edge, ext_tick;
   logic                  ext_half_q, ext_half2_q;
   logic                  xtal_mode;
   logic [15:0]           xtal_cnt_q;
   logic                  xtal_valid;
   logic [2:0]            ext8_cnt_q;
   logic                  ext8_q;

   // multiplier and selection
   logic                  mul_in_tick, mul_tick, mul_ready;
   logic                  old_tick, old_alive, new_tick;
   logic                  core_q;

   // register writes: internal oscillator control
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         osc_on_q <= CTRL_RESET[`OCS_INT_EN_BIT];
         div_q    <= `OCS_DIV_RESET;
      end
      else if (sfr_req.wr && sfr_req.addr == `OCS_ADDR_INT_CTRL)
      begin
         osc_on_q <= sfr_req.wdata[`OCS_INT_EN_BIT];
         div_q    <= sfr_req.wdata[1:0];             // bits 5..2 dropped
      end
   end

   // register writes: trim, bit 7 discarded
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         trim_q <= TRIM_RESET;
      else if (sfr_req.wr && sfr_req.addr == `OCS_ADDR_INT_TRIM)
         trim_q <= sfr_req.wdata[6:0];
   end

   // register writes: external oscillator control
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         ext_mode_q <= EXT_OFF0;
         range_q    <= 3'h0;
      end
      else if (sfr_req.wr && sfr_req.addr == `OCS_ADDR_EXT_CTRL)
      begin
         ext_mode_q <= ocs_ext_mode_type'(sfr_req.wdata[6:4]);
         range_q    <= sfr_req.wdata[2:0];
      end
   end

   // register writes: multiplier control, init made a pulse
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         mul_en_q       <= 1'b0;
         mul_sel_q      <= 2'h0;
         mul_init_q     <= 1'b0;
         mul_init_bit_q <= 1'b0;
      end
      else if (sfr_req.wr && sfr_req.addr == `OCS_ADDR_MULT_CTRL)
      begin
         mul_en_q       <= sfr_req.wdata[`OCS_MUL_EN_BIT];
         mul_init_bit_q <= sfr_req.wdata[`OCS_MUL_INIT_BIT];
         // reserved input code keeps the previous input
         if (sfr_req.wdata[1:0] != 2'h3)
            mul_sel_q <= sfr_req.wdata[1:0];
         mul_init_q <= sfr_req.wdata[`OCS_MUL_EN_BIT] & sfr_req.wdata[`OCS_MUL_INIT_BIT];
      end
      else
         mul_init_q <= 1'b0;
   end

   // register writes: core source, reserved code ignored
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         src_q <= SRC_INT;
      else if (sfr_req.wr && sfr_req.addr == `OCS_ADDR_CLK_SEL && sfr_req.wdata[1:0] != SRC_RSVD)
         src_q <= ocs_src_type'(sfr_req.wdata[1:0]);
   end

   // read data, one cycle after the strobe
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         rdata_q <= 8'h00;
      else if (sfr_req.rd)
      begin
         case (sfr_req.addr)
            `OCS_ADDR_INT_CTRL:  rdata_q <= {osc_on_q, int_ready, 4'h0, div_q};
            `OCS_ADDR_INT_TRIM:  rdata_q <= {1'b0, trim_q};
            `OCS_ADDR_EXT_CTRL:  rdata_q <= {xtal_valid, ext_mode_q, 1'b0, range_q};
            `OCS_ADDR_MULT_CTRL: rdata_q <= {mul_en_q, mul_init_bit_q, mul_ready, 3'h0, mul_sel_q};
            `OCS_ADDR_CLK_SEL:   rdata_q <= {6'h00, src_q};
            default:             rdata_q <= 8'h00;  // unmapped
         endcase
      end
   end

   assign sfr_rdata = rdata_q;

   // internal oscillator: phase accumulator stepped by the trim
   assign {nco_cy, nco_sum} = {1'b0, nco_q} + {1'b0, nco_inc(trim_q)};
   assign int_tick = osc_on_q & nco_cy;

   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         nco_q <= '0;
      else if (!osc_on_q)
         nco_q <= '0;
      else
         nco_q <= nco_sum;
   end

   // ready after a settle run of ticks; a new trim restarts it
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         rdy_cnt_q <= 4'h0;
      else if (!osc_on_q || (sfr_req.wr && sfr_req.addr == `OCS_ADDR_INT_TRIM))
         rdy_cnt_q <= 4'h0;
      else if (int_tick && rdy_cnt_q != `OCS_INT_READY_TICKS)
         rdy_cnt_q <= rdy_cnt_q + 4'h1;
   end

   assign int_ready = osc_on_q && rdy_cnt_q == `OCS_INT_READY_TICKS;

   // post-divider; new code taken only at the divide-by-8 boundary
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         pd_cnt_q  <= 3'h0;
         div_act_q <= `OCS_DIV_RESET;
      end
      else if (int_tick)
      begin
         pd_cnt_q <= pd_cnt_q + 3'h1;
         if (pd_cnt_q == 3'h7)
            div_act_q <= div_q;
      end
   end

   assign int_div_tick = int_tick && (pd_cnt_q & div_mask(div_act_q)) == div_mask(div_act_q);

   // internal oscillator over two for the multiplier
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         int_half_q <= 1'b0;
      else if (int_tick)
         int_half_q <= ~int_half_q;
   end

   // external pin level synchroniser and edge detect
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         ext_s1_q <= 1'b0;
         ext_s2_q <= 1'b0;
         ext_s3_q <= 1'b0;
      end
      else
      begin
         ext_s1_q <= crystal_pin_out_level;
         ext_s2_q <= ext_s1_q;
         ext_s3_q <= ext_s2_q;
      end
   end

   assign ext_on    = ext_mode_q[2:1] != 2'h0;
   assign xtal_mode = ext_mode_q[2:1] == 2'h3;
   assign ext_edge  = ext_on & ext_s2_q & ~ext_s3_q;

   // optional divide by two in cmos and crystal modes
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         ext_half_q <= 1'b0;
      else if (!ext_on)
         ext_half_q <= 1'b0;
      else if (ext_edge)
         ext_half_q <= ~ext_half_q;
   end

   assign ext_tick = ext_edge && (!(ext_mode_q[1] & ext_mode_q[0]) || ext_half_q);

   // crystal settling: count edges while in a crystal mode
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         xtal_cnt_q <= 16'h0000;
      else if (!xtal_mode)
         xtal_cnt_q <= 16'h0000;
      else if (ext_edge && xtal_cnt_q < 16'(XTAL_STABLE_EDGES))
         xtal_cnt_q <= xtal_cnt_q + 16'h0001;
   end

   assign xtal_valid = xtal_mode && xtal_cnt_q >= 16'(XTAL_STABLE_EDGES);

   // pins taken by the oscillator circuit
   assign p02_osc_claim = xtal_mode;
   assign p03_osc_claim = ext_on;

   // external over eight, registered on the core base clock
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         ext8_cnt_q <= 3'h0;
         ext8_q     <= 1'b0;
      end
      else
      begin
         ext8_q <= ext_tick && ext8_cnt_q == 3'h7;
         if (!ext_on)
            ext8_cnt_q <= 3'h0;
         else if (ext_tick)
            ext8_cnt_q <= ext8_cnt_q + 3'h1;
      end
   end

   assign ext_div8_tick = ext8_q;

   // external over two for the multiplier
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         ext_half2_q <= 1'b0;
      else if (ext_tick)
         ext_half2_q <= ~ext_half2_q;
   end

   // multiplier input choice: int/2, ext, ext/2
   always_comb
   begin
      case (mul_sel_q)
         2'h0:    mul_in_tick = int_tick & int_half_q;
         2'h1:    mul_in_tick = ext_tick;
         2'h2:    mul_in_tick = ext_tick & ext_half2_q;
         default: mul_in_tick = 1'b0;
      endcase
   end

   // times four on the chosen input
   ocs_clock_mult #(
      .W (`OCS_MULT_W)
   ) u_mult (
      .clk      (clk),
      .reset_n  (reset_n),
      .enable   (mul_en_q),
      .init     (mul_init_q),
      .in_tick  (mul_in_tick),
      .out_tick (mul_tick),
      .ready    (mul_ready)
   );

   // ticks and liveness of the active source, tick of the requested one
   always_comb
   begin
      case (src_act_q)
         SRC_EXT:  begin old_tick = ext_tick;     old_alive = ext_on;    end
         SRC_MULT: begin old_tick = mul_tick;     old_alive = mul_ready; end
         default:  begin old_tick = int_div_tick; old_alive = osc_on_q;  end
      endcase
      case (src_q)
         SRC_EXT:  new_tick = ext_tick;
         SRC_MULT: new_tick = mul_tick;
         default:  new_tick = int_div_tick;
      endcase
   end

   // switch only at an old-source tick, or once it is dead
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         sw_q      <= SW_RUN;
         src_act_q <= SRC_INT;
      end
      else
      begin
         unique case (sw_q)
            SW_RUN:
               if (src_q != src_act_q)
                  sw_q <= SW_WAIT;
            SW_WAIT:
               if (old_tick || !old_alive)
               begin
                  src_act_q <= src_q;
                  sw_q      <= SW_RUN;
               end
         endcase
      end
   end

   // core clock enable; the old source's switching tick still passes, never split
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         core_q <= 1'b0;
      else if (sw_q == SW_WAIT && (old_tick || !old_alive))
         core_q <= old_tick;
      else
         core_q <= old_tick;
   end

   assign core_clock = core_q;

   // analog settings
   assign internal_osc_on     = osc_on_q;
   assign internal_osc_trim   = trim_q;
   assign external_freq_range = range_q;

   // new source tick unused; the waiting rule looks only at the old source
   logic unused_new;
   assign unused_new = new_tick;

endmodule // ocs_top
`default_nettype wire
